// *** sogc_chk.sv ***
// Checker for the gating outputs and the device side of the link.
// Assumes instantiation beside the link interface in the bench top.
`timescale 1ns/10ps
`include "sogc_params.svh"
module sogc_chk (
   // Device clock and reset
   input wire logic                   reference_clock_input_i,
   input wire logic                   rst_i,
   // Control pins and gating outputs
   input wire logic                   power_good_powerdown_n_i,
   input wire logic [`SOGC_N_PIN-1:0] pin_gated_outputs_oe_n_i,
   input wire logic [`SOGC_N_OUT-1:0] buffered_clock_output_oe_o,
   input wire logic                   feedback_clock_output_oe_o,
   input wire logic                   pll_on_o,
   input wire logic [`SOGC_N_OUT-1:0] enable_bits_o,
   // Link wires
   input wire logic                   dev_sda_oe,
   input wire logic                   scl
);
   default clocking @(posedge reference_clock_input_i);
   endclocking
   default disable iff (rst_i);

   // Outputs 0-4 and 13-18 never look at a pin.
   wire logic [`SOGC_N_OUT-1:0] free_mask = 19'h7e01f;
   wire logic                   pg        = power_good_powerdown_n_i;
   wire logic                   pin5_n    = pin_gated_outputs_oe_n_i[0];
   wire logic                   oe5       = buffered_clock_output_oe_o[5];

   // =====================================================================
   // Gating
   pd_all_off_a: assert property ((!pg)[*4] |-> buffered_clock_output_oe_o == '0
      && !feedback_clock_output_oe_o && !pll_on_o) else $error("powerdown left a pair on");
   fb_pll_on_a: assert property (pg[*5] |-> feedback_clock_output_oe_o && pll_on_o)
      else $error("feedback or pll off while powered");
   bit_gates_a: assert property ((buffered_clock_output_oe_o & ~enable_bits_o
      & ~$past(enable_bits_o)) == '0) else $error("pair driven with enable bit 0");
   free_follow_a: assert property ((pg && $stable(enable_bits_o))[*5] |->
      (buffered_clock_output_oe_o & free_mask) == (enable_bits_o & free_mask))
      else $error("unpinned pair does not follow its bit");
   pin_stop_a: assert property ($rose(pin5_n) && oe5 |-> oe5[*4] ##[1:8] !oe5)
      else $error("pair stop outside latency window");
   pin_start_a: assert property ($fell(pin5_n) && !oe5 && pg && enable_bits_o[5] |->
      (!oe5)[*4] ##[1:8] oe5) else $error("pair start outside latency window");

   // =====================================================================
   // Link
   ack_stable_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device moved data while clock high");
   ack_short_a: assert property ($rose(dev_sda_oe) |-> ##[1:40] !dev_sda_oe)
      else $error("device held data low too long");
   rst_value_a: assert property (disable iff (1'b0) rst_i |-> enable_bits_o == '1
      && !pll_on_o && !dev_sda_oe) else $error("wrong reset state");

   cover property ($rose(dev_sda_oe));
   cover property ($rose(pin5_n) && oe5);
   cover property ($fell(pg));
endmodule : sogc_chk

// *** sogc_dev.sv ***
// Output gating device: SMBus block-write slave and per-pair gating.
// Assumes the reference clock runs while the host talks to it.
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "sogc_params.svh"
module sogc_dev #(
   parameter logic [6:0] SLAVE_ADDR = `SOGC_SLAVE_ADDR,
   parameter int         OE_DELAY   = `SOGC_OE_DELAY
) (
   // Clock, reset, enable
   input  wire logic                     reference_clock_input_i,
   input  wire logic                     rst_i,
   input  wire logic                     ce_i,
   // Control pins
   input  wire logic                     power_good_powerdown_n_i,
   input  wire logic [`SOGC_N_PIN-1:0]   pin_gated_outputs_oe_n_i,
   // SMBus
   sogc_smb_if.device                    smb,
   // Output state
   output logic      [`SOGC_N_OUT-1:0]   buffered_clock_output_oe_o,
   output logic                          feedback_clock_output_oe_o,
   output logic                          pll_on_o,
   output logic      [`SOGC_N_OUT-1:0]   enable_bits_o
);

   // ==================================================================
   // Pin synchronisers
   // The serial side runs on the reference clock, so a host that talks
   // while that clock is stopped is simply not heard.
   logic                   scl_s1_r;
   logic                   scl_s2_r;
   logic                   scl_d_r;
   logic                   sda_s1_r;
   logic                   sda_s2_r;
   logic                   sda_d_r;
   logic                   pg_s1_r;
   logic                   pg_s2_r;
   logic [`SOGC_N_PIN-1:0] oe_s1_r;
   logic [`SOGC_N_PIN-1:0] oe_s2_r;
   logic [`SOGC_N_PIN-1:0] oe_dly_r [OE_DELAY];

   always_ff @(posedge reference_clock_input_i or posedge rst_i) begin
      if (rst_i) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r  <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r  <= 1'b1;
         pg_s1_r  <= 1'b0;
         pg_s2_r  <= 1'b0;
         oe_s1_r  <= '1;
         oe_s2_r  <= '1;
      end else if (ce_i) begin
         scl_s1_r <= smb.scl;
         scl_s2_r <= scl_s1_r;
         scl_d_r  <= scl_s2_r;
         sda_s1_r <= smb.sda;
         sda_s2_r <= sda_s1_r;
         sda_d_r  <= sda_s2_r;
         pg_s1_r  <= power_good_powerdown_n_i;
         pg_s2_r  <= pg_s1_r;
         oe_s1_r  <= pin_gated_outputs_oe_n_i;
         oe_s2_r  <= oe_s1_r;
      end
   end

   // A short pipeline puts the pin response inside its latency window.
   genvar s;
   generate
      for (s = 0; s < OE_DELAY; s++) begin : g_oe_dly
         always_ff @(posedge reference_clock_input_i or posedge rst_i) begin
            if (rst_i) begin
               oe_dly_r[s] <= '1;
            end else if (ce_i) begin
               oe_dly_r[s] <= (s == 0) ? oe_s2_r : oe_dly_r[(s == 0) ? 0 : s-1];
            end
         end
      end
   endgenerate

   // ==================================================================
   // Bus event decode
   wire scl_rise = scl_s2_r & ~scl_d_r;
   wire scl_fall = ~scl_s2_r & scl_d_r;
   wire start_ev = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   wire stop_ev  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

   // ==================================================================
   // Block-write slave
   sogc_pkg::sogc_slv_e   phase_r;
   logic [3:0]            bitcnt_r;
   logic [7:0]            shift_r;
   logic [7:0]            index_r;
   logic [7:0]            left_r;
   logic                  ack_r;
   logic [`SOGC_N_OUT-1:0] en_r;

   wire addr_hit = (shift_r[7:1] == SLAVE_ADDR) & ~shift_r[0];
   wire byte_ok  = (phase_r == sogc_pkg::SL_ADDR)  ? addr_hit :
                   (phase_r == sogc_pkg::SL_INDEX) ? 1'b1 :
                   (phase_r == sogc_pkg::SL_COUNT) ? 1'b1 :
                   (phase_r == sogc_pkg::SL_DATA)  ? (left_r != 8'h00) :
                   1'b0;
   wire byte_end = scl_fall & (bitcnt_r == 4'd8);
   wire ack_end  = scl_fall & (bitcnt_r == 4'd9);
   wire data_wr  = byte_end & byte_ok & (phase_r == sogc_pkg::SL_DATA);

   sogc_pkg::sogc_slv_e phase_nxt;
   assign phase_nxt = !byte_ok                         ? sogc_pkg::SL_SKIP  :
                      (phase_r == sogc_pkg::SL_ADDR)   ? sogc_pkg::SL_INDEX :
                      (phase_r == sogc_pkg::SL_INDEX)  ? sogc_pkg::SL_COUNT :
                      sogc_pkg::SL_DATA;

   // Only the three enable bytes are writable; other indices are dropped.
   wire [`SOGC_N_OUT-1:0] en_nxt =
      (index_r == `SOGC_IDX_HI_EN)  ? {shift_r[5:3], en_r[15:0]} :
      (index_r == `SOGC_IDX_LO_EN)  ? {en_r[18:8], shift_r} :
      (index_r == `SOGC_IDX_MID_EN) ? {en_r[18:16], shift_r, en_r[7:0]} :
      en_r;

   always_ff @(posedge reference_clock_input_i or posedge rst_i) begin
      if (rst_i) begin
         phase_r  <= sogc_pkg::SL_IDLE;
         bitcnt_r <= 4'd0;
         shift_r  <= 8'h00;
         index_r  <= 8'h00;
         left_r   <= 8'h00;
         ack_r    <= 1'b0;
      end else if (ce_i) begin
         if (start_ev) begin
            phase_r  <= sogc_pkg::SL_ADDR;
            bitcnt_r <= 4'd0;
            ack_r    <= 1'b0;
         end else if (stop_ev) begin
            phase_r  <= sogc_pkg::SL_IDLE;
            ack_r    <= 1'b0;
         end else if (phase_r != sogc_pkg::SL_IDLE) begin
            if (scl_rise && bitcnt_r < 4'd8) begin
               shift_r  <= {shift_r[6:0], sda_s2_r};
               bitcnt_r <= bitcnt_r + 4'd1;
            end else if (byte_end) begin
               bitcnt_r <= 4'd9;
               ack_r    <= byte_ok;
               phase_r  <= phase_nxt;
               if (byte_ok && phase_r == sogc_pkg::SL_INDEX) begin
                  index_r <= shift_r;
               end
               if (byte_ok && phase_r == sogc_pkg::SL_COUNT) begin
                  left_r <= shift_r;
               end
               if (data_wr) begin
                  index_r <= index_r + 8'h01;
                  left_r  <= left_r - 8'h01;
               end
            end else if (ack_end) begin
               bitcnt_r <= 4'd0;
               ack_r    <= 1'b0;
            end
         end
      end
   end

   // Commits happen at the acknowledge, so a stop cannot undo a byte.
   always_ff @(posedge reference_clock_input_i or posedge rst_i) begin
      if (rst_i) begin
         en_r <= `SOGC_EN_RESET;
      end else if (ce_i && data_wr && !start_ev && !stop_ev) begin
         en_r <= en_nxt;
      end
   end

   assign smb.dev_sda_oe = ack_r;

   // ==================================================================
   // Output gating
   // All decisions are registered on the reference clock, so a pair
   // only starts or stops on a whole clock period.
   // A pair whose pin is released stops on the next output clock
   // boundary; the pipeline above sets how many periods that takes.
   wire  [`SOGC_N_OUT-1:0] drv_nxt;
   genvar i;
   generate
      for (i = 0; i < `SOGC_N_OUT; i++) begin : g_gate
         if (i >= `SOGC_PIN_LO && i < `SOGC_PIN_LO + `SOGC_N_PIN) begin : g_pin
            assign drv_nxt[i] = pg_s2_r & en_r[i]
                              & ~oe_dly_r[OE_DELAY-1][i-`SOGC_PIN_LO];
         end else begin : g_free
            assign drv_nxt[i] = pg_s2_r & en_r[i];
         end
      end
   endgenerate

   // Feedback and PLL depend on power good alone; enable bits and pins
   // gate only the output pairs.
   always_ff @(posedge reference_clock_input_i or posedge rst_i) begin
      if (rst_i) begin
         buffered_clock_output_oe_o <= '0;
         feedback_clock_output_oe_o <= 1'b0;
         pll_on_o                   <= 1'b0;
         enable_bits_o              <= `SOGC_EN_RESET;
      end else if (ce_i) begin
         buffered_clock_output_oe_o <= drv_nxt;
         feedback_clock_output_oe_o <= pg_s2_r;
         pll_on_o                   <= pg_s2_r;
         enable_bits_o              <= en_r;
      end
   end

endmodule : sogc_dev

// *** sogc_host.sv ***
// SMBus host: AHB-Lite registers order one block write to the device.
// Assumes a single AHB-Lite master and pull-ups on the bus wires.
`timescale 1ns/10ps
`include "sogc_params.svh"
module sogc_host #(
   parameter int QTR_CYC = `SOGC_QTR_CYC
) (
   // Clock, reset, enable
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic      [31:0] hrdata_o,
   // SMBus
   sogc_smb_if.host         smb
);

   // ==================================================================
   // Registers
   logic [7:0]  wr_addr_r;
   logic        wr_pend_r;
   logic [6:0]  slave_r;
   logic [7:0]  index_r;
   logic [2:0]  count_r;
   logic [31:0] data_r;
   logic        busy_r;
   logic        nack_r;
   logic        go_r;

   wire addr_ph  = hsel_i & htrans_i[1] & hready_i;
   wire wr_ctrl  = wr_pend_r & (wr_addr_r == `SOGC_REG_CTRL);
   wire start_ok = wr_ctrl & hwdata_i[0] & ~busy_r;
   wire [31:0] rd_val =
      (haddr_i[7:0] == `SOGC_REG_CTRL)   ? {17'h0, slave_r, 8'h00} :
      (haddr_i[7:0] == `SOGC_REG_INDEX)  ? {24'h0, index_r} :
      (haddr_i[7:0] == `SOGC_REG_COUNT)  ? {29'h0, count_r} :
      (haddr_i[7:0] == `SOGC_REG_DATA)   ? data_r :
      (haddr_i[7:0] == `SOGC_REG_STATUS) ? {30'h0, nack_r, busy_r} :
      32'h0;

   logic mst_done;
   logic mst_nack;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
         hrdata_o    <= 32'h0;
         wr_addr_r   <= 8'h00;
         wr_pend_r   <= 1'b0;
         slave_r     <= `SOGC_SLAVE_ADDR;
         index_r     <= 8'h00;
         count_r     <= 3'd1;
         data_r      <= 32'h0;
         busy_r      <= 1'b0;
         nack_r      <= 1'b0;
         go_r        <= 1'b0;
      end else if (ce_i) begin
         wr_pend_r <= addr_ph & hwrite_i;
         wr_addr_r <= haddr_i[7:0];
         hrdata_o  <= (addr_ph && !hwrite_i) ? rd_val : 32'h0;
         go_r      <= start_ok;
         if (wr_ctrl) begin
            slave_r <= hwdata_i[14:8];
         end
         if (wr_pend_r && wr_addr_r == `SOGC_REG_INDEX) begin
            index_r <= hwdata_i[7:0];
         end
         if (wr_pend_r && wr_addr_r == `SOGC_REG_COUNT) begin
            count_r <= hwdata_i[2:0];
         end
         if (wr_pend_r && wr_addr_r == `SOGC_REG_DATA) begin
            data_r <= hwdata_i;
         end
         // A start only happens while idle, so it never meets a new nack.
         if (start_ok) begin
            busy_r <= 1'b1;
            nack_r <= 1'b0;
         end else if (mst_done) begin
            busy_r <= 1'b0;
            nack_r <= nack_r | mst_nack;
         end
      end
   end

   // ==================================================================
   // Bit engine: four quarters per bit, derived from the core clock
   sogc_pkg::sogc_mst_e state_r;
   logic [15:0] div_r;
   logic [1:0]  q_r;
   logic [3:0]  bitn_r;
   logic [2:0]  byten_r;
   logic        scl_drv_r;
   logic        sda_drv_r;
   logic        sda_s1_r;
   logic        sda_s2_r;
   logic        nk_r;

   wire tick = (div_r == 16'h0);
   wire [7:0] cur_byte =
      (byten_r == 3'd0) ? {slave_r, 1'b0} :
      (byten_r == 3'd1) ? index_r :
      (byten_r == 3'd2) ? {5'h0, count_r} :
      data_r[8*(byten_r-3'd3) +: 8];
   wire last_byte = (byten_r == count_r + 3'd2);
   wire is_ack    = (bitn_r == 4'd8);

   assign mst_done = tick & (state_r == sogc_pkg::M_STOP) & (q_r == 2'd3);
   assign mst_nack = nk_r;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r   <= sogc_pkg::M_IDLE;
         div_r     <= 16'h0;
         q_r       <= 2'd0;
         bitn_r    <= 4'd0;
         byten_r   <= 3'd0;
         scl_drv_r <= 1'b0;
         sda_drv_r <= 1'b0;
         sda_s1_r  <= 1'b1;
         sda_s2_r  <= 1'b1;
         nk_r      <= 1'b0;
      end else if (ce_i) begin
         sda_s1_r <= smb.sda;
         sda_s2_r <= sda_s1_r;
         div_r    <= tick ? 16'(QTR_CYC - 1) : div_r - 16'h1;
         if (state_r == sogc_pkg::M_IDLE) begin
            q_r <= 2'd0;
            if (go_r) begin
               state_r <= sogc_pkg::M_START;
               nk_r    <= 1'b0;
               byten_r <= 3'd0;
            end
         end else if (tick) begin
            q_r <= q_r + 2'd1;
            unique case (state_r)
               sogc_pkg::M_START: begin
                  if (q_r == 2'd0) sda_drv_r <= 1'b1;
                  if (q_r == 2'd1) scl_drv_r <= 1'b1;
                  if (q_r == 2'd3) begin
                     state_r <= sogc_pkg::M_BIT;
                     bitn_r  <= 4'd0;
                  end
               end
               sogc_pkg::M_BIT: begin
                  if (q_r == 2'd0) sda_drv_r <= ~is_ack & ~cur_byte[3'd7 - bitn_r[2:0]];
                  if (q_r == 2'd1) scl_drv_r <= 1'b0;
                  if (q_r == 2'd2 && is_ack) nk_r <= sda_s2_r;
                  if (q_r == 2'd3) begin
                     scl_drv_r <= 1'b1;
                     bitn_r    <= is_ack ? 4'd0 : bitn_r + 4'd1;
                     if (is_ack) begin
                        byten_r <= byten_r + 3'd1;
                        if (nk_r || last_byte) state_r <= sogc_pkg::M_STOP;
                     end
                  end
               end
               sogc_pkg::M_STOP: begin
                  if (q_r == 2'd0) sda_drv_r <= 1'b1;
                  if (q_r == 2'd1) scl_drv_r <= 1'b0;
                  if (q_r == 2'd2) sda_drv_r <= 1'b0;
                  if (q_r == 2'd3) state_r <= sogc_pkg::M_IDLE;
               end
               default: state_r <= sogc_pkg::M_IDLE;
            endcase
         end
      end
   end

   assign smb.host_scl_oe = scl_drv_r;
   assign smb.host_sda_oe = sda_drv_r;

endmodule : sogc_host

// *** sogc_params.svh ***
// Constants shared by the output gating device and its SMBus host.
// Assumes inclusion by bare name from each design file.
`ifndef SOGC_PARAMS_SVH
`define SOGC_PARAMS_SVH

// =====================================================================
// Device map
`define SOGC_N_OUT        19
`define SOGC_N_PIN        8
`define SOGC_PIN_LO       5
`define SOGC_IDX_HI_EN    8'h00
`define SOGC_IDX_LO_EN    8'h01
`define SOGC_IDX_MID_EN   8'h02
`define SOGC_EN_RESET     19'h7ffff
`define SOGC_OE_DELAY     4
// Arbitrary neutral default address.
`define SOGC_SLAVE_ADDR   7'h50

// =====================================================================
// Host registers and timing
`define SOGC_REG_CTRL     8'h00
`define SOGC_REG_INDEX    8'h04
`define SOGC_REG_COUNT    8'h08
`define SOGC_REG_DATA     8'h0c
`define SOGC_REG_STATUS   8'h10
`define SOGC_CLK_NS       20
`define SOGC_SMB_NS       10000
`define SOGC_QTR_CYC      (`SOGC_SMB_NS / 4 / `SOGC_CLK_NS)

`endif

// *** sogc_pkg.sv ***
// Types shared by both ends of the configuration link.
// Assumes nothing of its surroundings.
package sogc_pkg;
   typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_INDEX, SL_COUNT, SL_DATA, SL_SKIP} sogc_slv_e;
   typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} sogc_mst_e;
endpackage : sogc_pkg

// *** sogc_smb_if.sv ***
// Open-drain SMBus wires between host and device.
// Assumes each end drives low only through its output enable.
`timescale 1ns/10ps
interface sogc_smb_if;
   logic host_scl_oe;
   logic host_sda_oe;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // Pull-ups make the wired-AND of all low drivers.
   assign scl = ~host_scl_oe;
   assign sda = ~(host_sda_oe | dev_sda_oe);

   modport host (output host_scl_oe, output host_sda_oe, input scl, input sda);
   modport device (output dev_sda_oe, input scl, input sda);
endinterface : sogc_smb_if

// *** test_smbus_output_gating_control.sv ***
// Self-checking bench: host and device joined by the link interface.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/10ps
`include "sogc_params.svh"
module test_smbus_output_gating_control;
   logic                   core_clk_i, ref_clk, rst_i, pg, hwrite, hreadyout, hresp;
   logic [1:0]             htrans;
   logic [31:0]            haddr, hwdata, hrdata, st;
   logic [`SOGC_N_PIN-1:0] pin_n;
   logic [`SOGC_N_OUT-1:0] oe, en;
   logic                   fb, pll;
   int                     n_mismatch, tests_run;
   localparam logic [6:0]  SA = `SOGC_SLAVE_ADDR;

   sogc_smb_if smb_link ();
   sogc_host #(.QTR_CYC(8)) sogc_host_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
      .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp),
      .hrdata_o(hrdata), .smb(smb_link));
   sogc_dev sogc_dev_i (.reference_clock_input_i(ref_clk), .rst_i(rst_i), .ce_i(1'b1),
      .power_good_powerdown_n_i(pg), .pin_gated_outputs_oe_n_i(pin_n), .smb(smb_link),
      .buffered_clock_output_oe_o(oe), .feedback_clock_output_oe_o(fb), .pll_on_o(pll),
      .enable_bits_o(en));
   sogc_chk sogc_chk_i (.reference_clock_input_i(ref_clk), .rst_i(rst_i),
      .power_good_powerdown_n_i(pg), .pin_gated_outputs_oe_n_i(pin_n),
      .buffered_clock_output_oe_o(oe), .feedback_clock_output_oe_o(fb), .pll_on_o(pll),
      .enable_bits_o(en), .dev_sda_oe(smb_link.dev_sda_oe), .scl(smb_link.scl));

   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   // The reference clock is unrelated in phase to the core clock.
   initial begin
      ref_clk = 1'b0;
      #3;
      forever #24 ref_clk = ~ref_clk;
   end

   // =====================================================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict;
      $display("comparisons=%0d mismatches=%0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1) begin
         n_mismatch++;
         print_verdict();
      end
   endtask : wait_rdy

   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : ahb

   // Leaves the caller just after a core clock edge.
   task automatic ref_wait(input int n);
      repeat (n) @(posedge ref_clk);
      @(posedge core_clk_i);
   endtask : ref_wait

   task automatic smb_go(input logic [6:0] sa, input logic [7:0] idx, input logic [2:0] cnt,
                         input logic [31:0] data);
      int n;
      ahb(1'b1, {24'h0, `SOGC_REG_INDEX}, {24'h0, idx}, st);
      ahb(1'b1, {24'h0, `SOGC_REG_COUNT}, {29'h0, cnt}, st);
      ahb(1'b1, {24'h0, `SOGC_REG_DATA}, data, st);
      ahb(1'b1, {24'h0, `SOGC_REG_CTRL}, {17'h0, sa, 8'h01}, st);
      n = 0;
      do begin
         ahb(1'b0, {24'h0, `SOGC_REG_STATUS}, 32'h0, st);
         n++;
      end while (st[0] !== 1'b0 && n < 5000);
      if (st[0] !== 1'b0) begin
         n_mismatch++;
         print_verdict();
      end
      ref_wait(4);
      check({smb_link.scl, smb_link.sda}, 32'h3);
      check({hreadyout, hresp}, 32'h2);
   endtask : smb_go

   // =====================================================================
   // Scenarios
   task automatic t_power_up;
      ref_wait(6);
      check(oe, 32'h0);
      check({fb, pll}, 32'h0);
      check(en, 32'h7ffff);
      pg <= 1'b1;
      ref_wait(6);
      check(oe, 32'h7ffff);
      check({fb, pll}, 32'h3);
   endtask : t_power_up

   task automatic t_block_write;
      smb_go(SA, 8'h01, 3'd2, 32'h0000_c35a);
      check(st, 32'h0);
      check(en, 32'h7c35a);
      check(oe, 32'h7c35a);
      // Count at its top; index 3 is acknowledged but stores nothing.
      smb_go(SA, 8'h00, 3'd4, 32'h00ff_ff28);
      check(st, 32'h0);
      check(en, 32'h5ffff);
      check({fb, pll}, 32'h3);
      ahb(1'b0, 32'h0000_0020, 32'h0, st);
      check(st, 32'h0);
   endtask : t_block_write

   task automatic t_wrong_addr;
      smb_go(SA ^ 7'h01, 8'h01, 3'd1, 32'h0000_0000);
      check(st, 32'h2);
      check(en, 32'h5ffff);
   endtask : t_wrong_addr

   task automatic t_pins;
      pin_n <= 8'hff;
      ref_wait(13);
      check(oe, 32'h5e01f);
      check(fb, 32'h1);
      pin_n <= 8'h00;
      ref_wait(13);
      check(oe, 32'h5ffff);
   endtask : t_pins

   task automatic t_powerdown;
      pg <= 1'b0;
      ref_wait(6);
      check(oe, 32'h0);
      check({fb, pll}, 32'h0);
   endtask : t_powerdown

   initial begin
      rst_i      = 1'b0;
      pg         = 1'b0;
      pin_n      = '0;
      htrans     = 2'b00;
      haddr      = '0;
      hwrite     = 1'b0;
      hwdata     = '0;
      n_mismatch = 0;
      tests_run  = 0;
      // A clean rising edge on reset, so no process can miss it at time zero.
      #1;
      rst_i      = 1'b1;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      t_power_up();
      t_block_write();
      t_wrong_addr();
      t_pins();
      t_powerdown();
      print_verdict();
   end
endmodule : test_smbus_output_gating_control
